//--- pin_filter.sv
// Three-stage synchroniser and agreement filter for one bus pin.
`timescale 1ns/1ps
`default_nettype none
module pin_filter
(
    // Clock and reset.
    input wire logic clk,
    input wire logic srst,
    // Raw pin and filtered level.
    input wire logic pin,
    output logic level
);
    logic [2:0] sync_r;
    logic level_r;

    // The level moves only once the second and third stages agree.
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            sync_r <= 3'h7;
            level_r <= 1'b1;
        end
        else
        begin
            sync_r <= {sync_r[1:0], pin};
            if (sync_r[1] == sync_r[2])
                level_r <= sync_r[2];
        end
    end

    assign level = level_r;
endmodule // pin_filter
`default_nettype wire

//--- quarter_tick.sv
// Free-running divider giving one pulse per quarter bit period.
`timescale 1ns/1ps
`default_nettype none
module quarter_tick
import two_wire_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic srst,
    // One-cycle pulse.
    output logic tick
);
    logic [QTR_W-1:0] cnt_r;
    logic tick_r;
    wire wrap = (cnt_r == QTR_LAST);

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            cnt_r <= '0;
            tick_r <= 1'b0;
        end
        else
        begin
            cnt_r <= wrap ? '0 : cnt_r + 1'b1;
            tick_r <= wrap;
        end
    end

    assign tick = tick_r;
endmodule // quarter_tick
`default_nettype wire

//--- slave_model.sv
// Behavioural slave transmitter that answers read transfers on the bus.
`timescale 1ns/1ps
`default_nettype none
module slave_model #(parameter logic [6:0] ADR = 7'h2a, parameter logic [7:0] D0 = 8'h3c)
(
    // Bus lines, wired-and with pull-ups.
    input wire logic scl,
    input wire logic sda,
    output logic sda_oe
);
    logic [7:0] sh;
    logic [7:0] tx;
    logic ack;
    initial
    begin
        sda_oe = 1'b0;
        forever
        begin
            @(negedge sda iff scl);
            repeat (8) @(posedge scl) sh = {sh[6:0], sda};
            @(negedge scl);
            if (sh == {ADR, 1'b1})
            begin
                sda_oe = 1'b1;
                @(negedge scl);
                tx = D0;
                ack = 1'b1;
                while (ack)
                begin
                    for (int i = 7; i >= 0; i--)
                    begin
                        sda_oe = !tx[i];
                        @(negedge scl);
                    end
                    sda_oe = 1'b0;
                    @(posedge scl) ack = !sda;
                    tx = tx + 8'h01;
                    // A NACK may be followed by a repeated START, so do not wait here then.
                    if (ack)
                        @(negedge scl);
                end
            end
        end
    end
endmodule // slave_model
`default_nettype wire

//--- two_wire_master_receiver.sv
// Two-wire bus master receiver with registers, events and pin control.
`timescale 1ns/1ps
`default_nettype none
module two_wire_master_receiver
import two_wire_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic srst,
    // Register port.
    input wire logic [2:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [7:0] rdata,
    // Interrupt.
    output logic irq,
    // Bus clock line.
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe,
    // Bus data line.
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe
);
    state_t state_r;
    logic [1:0] phase_r;
    logic [3:0] bit_cnt_r;
    logic [8:0] tx_sh_r;
    logic [8:0] rx_sh_r;
    logic addr_ph_r;
    logic mode_rx_r;
    logic rep_r;
    logic ack_sent_r;
    logic flag_r;
    logic flag_q_r;
    logic en_r;
    logic ack_r;
    logic sta_r;
    logic sto_r;
    logic [7:0] status_r;
    logic [PRESC_W-1:0] presc_r;
    logic [7:0] data_r;
    logic arb_p_r;
    logic stop_p_r;
    logic [EV_W-1:0] ev_r;
    logic [EV_W-1:0] mask_r;
    logic irq_r;
    logic [7:0] rdata_r;
    logic scl_oe_r;
    logic sda_oe_r;
    logic scl_o_r;
    logic sda_o_r;
    logic scl_d_r;
    logic sda_d_r;
    logic busy_r;
    logic scl_f;
    logic sda_f;
    logic tick;

    pin_filter u_scl_filter (
        .clk(clk),
        .srst(srst),
        .pin(scl_i),
        .level(scl_f)
    );

    pin_filter u_sda_filter (
        .clk(clk),
        .srst(srst),
        .pin(sda_i),
        .level(sda_f)
    );

    quarter_tick u_quarter_tick (
        .clk(clk),
        .srst(srst),
        .tick(tick)
    );

    // Register port decode.
    wire ctrl_wr = wr_en && (addr == REG_CTRL);
    wire stat_wr = wr_en && (addr == REG_STAT);
    wire data_wr = wr_en && (addr == REG_DATA);
    wire evst_wr = wr_en && (addr == REG_EVST);
    wire evmsk_wr = wr_en && (addr == REG_EVMSK);
    wire flag_clr = ctrl_wr && wdata[CTRL_FLAG];
    wire [7:0] ctrl_rd = {flag_r, ack_r, sta_r, sto_r, 1'b0, en_r, 2'h0};
    wire [7:0] stat_rd = {status_r[7:STAT_CODE_LSB], 1'b0, presc_r};
    wire [7:0] rd_mux = (addr == REG_CTRL) ? ctrl_rd :
                        (addr == REG_STAT) ? stat_rd :
                        (addr == REG_DATA) ? data_r :
                        (addr == REG_EVST) ? {5'h00, ev_r} :
                        (addr == REG_EVMSK) ? {5'h00, mask_r} : 8'h00;

    // Bus conditions seen on the filtered lines.
    wire start_seen = scl_f && scl_d_r && sda_d_r && !sda_f;
    wire stop_seen = scl_f && scl_d_r && !sda_d_r && sda_f;

    // Frame decode for the shift engine.
    wire last_bit = (bit_cnt_r == ACK_BIT);
    wire arb_chk = addr_ph_r ? !last_bit : last_bit;
    wire lost = arb_chk && tx_sh_r[8] && !sda_f;
    wire got_ack = !rx_sh_r[0];
    wire [7:0] addr_code = mode_rx_r ? (got_ack ? ST_ADDR_ACK : ST_ADDR_NACK)
                                     : (got_ack ? ST_WADDR_ACK : ST_WADDR_NACK);
    wire [7:0] data_code = ack_sent_r ? ST_DATA_ACK : ST_DATA_NACK;
    // A disabled interface leaves the hold state through the abort path, not through go.
    wire go = (state_r == S_HOLD) && !flag_r && en_r;
    wire [EV_W-1:0] ev_set = {stop_p_r, arb_p_r, flag_r && !flag_q_r};

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
            busy_r <= 1'b0;
        end
        else
        begin
            scl_d_r <= scl_f;
            sda_d_r <= sda_f;
            if (start_seen)
                busy_r <= 1'b1;
            else if (stop_seen)
                busy_r <= 1'b0;
        end
    end

    // Bus sequencer; it also owns the flag, status and data registers.
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            state_r <= S_IDLE;
            phase_r <= PH_DRIVE;
            bit_cnt_r <= 4'h0;
            tx_sh_r <= 9'h1ff;
            rx_sh_r <= 9'h000;
            addr_ph_r <= 1'b0;
            mode_rx_r <= 1'b0;
            rep_r <= 1'b0;
            ack_sent_r <= 1'b0;
            flag_r <= 1'b0;
            en_r <= 1'b0;
            ack_r <= 1'b0;
            sta_r <= 1'b0;
            sto_r <= 1'b0;
            status_r <= ST_IDLE;
            presc_r <= '0;
            data_r <= 8'h00;
            arb_p_r <= 1'b0;
            stop_p_r <= 1'b0;
            scl_oe_r <= 1'b0;
            sda_oe_r <= 1'b0;
        end
        else
        begin
            arb_p_r <= 1'b0;
            stop_p_r <= 1'b0;
            if (flag_clr)
                flag_r <= 1'b0;
            if (data_wr)
                data_r <= wdata;
            if (stat_wr)
                presc_r <= wdata[PRESC_W-1:0];
            if (!en_r && state_r != S_IDLE)
            begin
                // Disabling the interface drops the bus at once.
                state_r <= S_IDLE;
                scl_oe_r <= 1'b0;
                sda_oe_r <= 1'b0;
                rep_r <= 1'b0;
            end
            else
            begin
                case (state_r)
                    S_IDLE:
                    begin
                        scl_oe_r <= 1'b0;
                        sda_oe_r <= 1'b0;
                        if (en_r && sta_r && !flag_r)
                            state_r <= S_WAIT_FREE;
                    end
                    S_WAIT_FREE:
                    begin
                        if (tick && !busy_r)
                        begin
                            state_r <= S_START;
                            phase_r <= PH_DRIVE;
                        end
                    end
                    S_START:
                    begin
                        if (tick)
                        begin
                            case (phase_r)
                                PH_DRIVE:
                                begin
                                    sda_oe_r <= 1'b0;
                                    phase_r <= PH_RISE;
                                end
                                PH_RISE:
                                begin
                                    scl_oe_r <= 1'b0;
                                    phase_r <= PH_HIGH;
                                end
                                PH_HIGH:
                                begin
                                    if (scl_f)
                                    begin
                                        sda_oe_r <= 1'b1;
                                        phase_r <= PH_FALL;
                                    end
                                end
                                default:
                                begin
                                    scl_oe_r <= 1'b1;
                                    status_r <= rep_r ? ST_REP : ST_START;
                                    flag_r <= 1'b1;
                                    rep_r <= 1'b1;
                                    state_r <= S_HOLD;
                                end
                            endcase
                        end
                    end
                    S_HOLD:
                    begin
                        // The clock is only stretched while still owning the bus.
                        scl_oe_r <= (status_r != ST_ARB);
                        if (!flag_r)
                        begin
                            phase_r <= PH_DRIVE;
                            bit_cnt_r <= 4'h0;
                            case (status_r)
                                ST_START, ST_REP:
                                begin
                                    tx_sh_r <= {data_r, 1'b1};
                                    addr_ph_r <= 1'b1;
                                    mode_rx_r <= data_r[0];
                                    state_r <= S_XFER;
                                end
                                ST_ADDR_ACK, ST_DATA_ACK:
                                begin
                                    tx_sh_r <= {8'hff, !ack_r};
                                    ack_sent_r <= ack_r;
                                    addr_ph_r <= 1'b0;
                                    state_r <= S_XFER;
                                end
                                ST_ARB:
                                begin
                                    // Idle restarts the START when it is still requested.
                                    state_r <= S_IDLE;
                                    status_r <= ST_IDLE;
                                    rep_r <= 1'b0;
                                end
                                default:
                                begin
                                    if (sto_r || !sta_r)
                                        state_r <= S_STOP;
                                    else
                                        state_r <= S_START;
                                end
                            endcase
                        end
                    end
                    S_XFER:
                    begin
                        if (tick)
                        begin
                            case (phase_r)
                                PH_DRIVE:
                                begin
                                    sda_oe_r <= !tx_sh_r[8];
                                    phase_r <= PH_RISE;
                                end
                                PH_RISE:
                                begin
                                    scl_oe_r <= 1'b0;
                                    phase_r <= PH_HIGH;
                                end
                                PH_HIGH:
                                begin
                                    // A slave stretching the clock holds this phase.
                                    if (scl_f)
                                    begin
                                        rx_sh_r <= {rx_sh_r[7:0], sda_f};
                                        phase_r <= PH_FALL;
                                        if (lost)
                                        begin
                                            sda_oe_r <= 1'b0;
                                            status_r <= ST_ARB;
                                            flag_r <= 1'b1;
                                            arb_p_r <= 1'b1;
                                            rep_r <= 1'b0;
                                            state_r <= S_HOLD;
                                        end
                                    end
                                end
                                default:
                                begin
                                    scl_oe_r <= 1'b1;
                                    tx_sh_r <= {tx_sh_r[7:0], 1'b1};
                                    bit_cnt_r <= bit_cnt_r + 4'h1;
                                    phase_r <= PH_DRIVE;
                                    if (last_bit)
                                    begin
                                        flag_r <= 1'b1;
                                        state_r <= S_HOLD;
                                        if (addr_ph_r)
                                            status_r <= addr_code;
                                        else
                                        begin
                                            data_r <= rx_sh_r[8:1];
                                            status_r <= data_code;
                                        end
                                    end
                                end
                            endcase
                        end
                    end
                    S_STOP:
                    begin
                        if (tick)
                        begin
                            case (phase_r)
                                PH_DRIVE:
                                begin
                                    sda_oe_r <= 1'b1;
                                    phase_r <= PH_RISE;
                                end
                                PH_RISE:
                                begin
                                    scl_oe_r <= 1'b0;
                                    phase_r <= PH_HIGH;
                                end
                                PH_HIGH:
                                begin
                                    if (scl_f)
                                    begin
                                        sda_oe_r <= 1'b0;
                                        phase_r <= PH_FALL;
                                    end
                                end
                                default:
                                begin
                                    sto_r <= 1'b0;
                                    stop_p_r <= 1'b1;
                                    rep_r <= 1'b0;
                                    status_r <= ST_IDLE;
                                    state_r <= S_IDLE;
                                end
                            endcase
                        end
                    end
                    default:
                        state_r <= S_IDLE;
                endcase
            end
            // Software writes come last so that a set request outlives a hardware clear.
            if (ctrl_wr)
            begin
                en_r <= wdata[CTRL_EN];
                ack_r <= wdata[CTRL_ACK];
                sta_r <= wdata[CTRL_STA];
                if (wdata[CTRL_STO])
                    sto_r <= 1'b1;
            end
        end
    end

    // Events, mask, interrupt and read data.
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            flag_q_r <= 1'b0;
            ev_r <= EV_RST;
            mask_r <= EV_RST;
            irq_r <= 1'b0;
            rdata_r <= 8'h00;
            scl_o_r <= 1'b0;
            sda_o_r <= 1'b0;
        end
        else
        begin
            flag_q_r <= flag_r;
            ev_r <= (ev_r & ~(evst_wr ? wdata[EV_W-1:0] : EV_RST)) | ev_set;
            if (evmsk_wr)
                mask_r <= wdata[EV_W-1:0];
            irq_r <= |(ev_r & mask_r);
            rdata_r <= rd_en ? rd_mux : 8'h00;
            scl_o_r <= 1'b0;
            sda_o_r <= 1'b0;
        end
    end

    assign rdata = rdata_r;
    assign irq = irq_r;
    assign scl_o = scl_o_r;
    assign sda_o = sda_o_r;
    assign scl_oe = scl_oe_r;
    assign sda_oe = sda_oe_r;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    chk_flag_clear: assert property (flag_r && flag_clr |=> !flag_r)
        else $error("flag survived a clearing write");
    chk_flag_keeps: assert property (flag_r && !flag_clr |=> flag_r)
        else $error("flag dropped without a clearing write");
    chk_wait_free: assert property (state_r == S_WAIT_FREE && busy_r && en_r |=> state_r == S_WAIT_FREE)
        else $error("start issued while bus busy");
    chk_start_code: assert property ($rose(flag_r) && $past(state_r) == S_START
        |-> (status_r == ST_START) != $past(rep_r))
        else $error("wrong code after start");
    chk_mode_pick: assert property (go && (status_r == ST_START || status_r == ST_REP)
        |=> mode_rx_r == $past(data_r[0]) && state_r == S_XFER)
        else $error("direction bit not taken");
    chk_ack_level: assert property (go && (status_r == ST_ADDR_ACK || status_r == ST_DATA_ACK)
        |=> tx_sh_r[0] == !$past(ack_r))
        else $error("ack bit differs from ack enable");
    chk_rx_byte: assert property ($rose(flag_r) && (status_r == ST_DATA_ACK || status_r == ST_DATA_NACK)
        |-> data_r == $past(rx_sh_r[8:1]))
        else $error("received byte not in data register");
    chk_arb_free: assert property (state_r == S_HOLD && status_r == ST_ARB
        |-> !sda_oe_r ##1 !scl_oe_r && !sda_oe_r)
        else $error("bus kept after arbitration loss");
    chk_stop_clr: assert property (state_r == S_STOP && tick && phase_r == PH_FALL && en_r
        && !(ctrl_wr && wdata[CTRL_STO]) |=> !sto_r && stop_p_r && state_r == S_IDLE)
        else $error("stop request not cleared");
    chk_hold_scl: assert property (state_r == S_HOLD && status_r != ST_ARB |-> scl_oe_r)
        else $error("clock released while flag pending");
    chk_irq_level: assert property (|(ev_r & mask_r) |=> irq_r)
        else $error("unmasked event without interrupt");

    cov_start: cover property ($rose(flag_r) && status_r == ST_START);
    cov_byte_nack: cover property ($rose(flag_r) && status_r == ST_DATA_NACK);
    cov_arb: cover property (arb_p_r);
    cov_stop: cover property (stop_p_r);
endmodule // two_wire_master_receiver
`default_nettype wire

//--- two_wire_master_receiver_tb.sv
// Testbench for the two-wire master receiver with a slave model on the bus.
`timescale 1ns/1ps
`default_nettype none
module two_wire_master_receiver_tb;
import two_wire_pkg::*;
    localparam logic [6:0] ADR = 7'h2a;
    localparam logic [7:0] D0 = 8'h3c;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic rd_d = 1'b0;
    logic [7:0] rdata;
    logic irq, scl_o, scl_oe, sda_o, sda_oe, slv_oe;
    wire logic scl = !scl_oe;
    wire logic sda = !(sda_oe || slv_oe);
    int n_errors = 0;
    int samples_checked = 0;
    int seed = 70950;
    logic [15:0] q[$];
    always #12.5 clk = !clk;
    two_wire_master_receiver dut (.clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr_en(wr_en),
        .rd_en(rd_en), .rdata(rdata), .irq(irq), .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe),
        .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe));
    slave_model #(.ADR(ADR), .D0(D0)) slv (.scl(scl), .sda(sda), .sda_oe(slv_oe));
    task finish_test;
        if (n_errors == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Read data stand one cycle after the strobe, so the check runs one edge behind it.
    always @(posedge clk)
    begin
        if (rd_d)
        begin
            samples_checked++;
            if ((rdata & q[0][15:8]) !== q[0][7:0])
            begin
                n_errors++;
                $display("Error at %0t: got %h expected %h", $time, rdata & q[0][15:8], q[0][7:0]);
            end
            void'(q.pop_front());
        end
        // The line outputs are open drain, so their data level must never leave zero.
        if (!srst && (scl_o !== 1'b0 || sda_o !== 1'b0))
        begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, {scl_o, sda_o}, 2'h0);
        end
        rd_d <= rd_en;
    end
    task wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask
    task rd(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m = 8'hff);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        q.push_back({m, e});
        @(posedge clk);
        rd_en <= 1'b0;
    endtask
    task wait_irq(input logic [7:0] c);
        int i;
        for (i = 0; i < 5000 && irq !== 1'b1; i++)
            @(posedge clk);
        if (i == 5000)
        begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, irq, 1'b1);
            finish_test();
        end
        else
            wr(REG_EVST, c);
    endtask
    initial
    begin
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        rd(REG_STAT, ST_IDLE);
        wr(REG_EVMSK, 8'h05);
        wr(REG_STAT, 8'($random(seed)));
        wr(REG_CTRL, 8'ha4);
        wait_irq(8'h01);
        rd(REG_STAT, ST_START, 8'hf8);
        wr(REG_DATA, {ADR, 1'b1});
        wr(REG_CTRL, 8'hc4);
        wait_irq(8'h01);
        rd(REG_STAT, ST_ADDR_ACK, 8'hf8);
        wr(REG_CTRL, 8'hc4);
        wait_irq(8'h01);
        rd(REG_STAT, ST_DATA_ACK, 8'hf8);
        rd(REG_DATA, D0);
        wr(REG_CTRL, 8'h84);
        wait_irq(8'h01);
        rd(REG_STAT, ST_DATA_NACK, 8'hf8);
        rd(REG_DATA, D0 + 8'h01);
        wr(REG_CTRL, 8'ha4);
        wait_irq(8'h01);
        rd(REG_STAT, ST_REP, 8'hf8);
        wr(REG_DATA, {ADR ^ 7'h01, 1'b1});
        wr(REG_CTRL, 8'h84);
        wait_irq(8'h01);
        rd(REG_STAT, ST_ADDR_NACK, 8'hf8);
        wr(REG_CTRL, 8'hb4);
        wait_irq(8'h04);
        rd(REG_CTRL, 8'h24, 8'h34);
        wait_irq(8'h01);
        rd(REG_STAT, ST_START, 8'hf8);
        wr(REG_DATA, {ADR ^ 7'h01, 1'b0});
        wr(REG_CTRL, 8'h84);
        wait_irq(8'h01);
        rd(REG_STAT, ST_WADDR_NACK, 8'hf8);
        wr(REG_CTRL, 8'h94);
        wait_irq(8'h04);
        rd(REG_CTRL, 8'h04, 8'h34);
        rd(REG_STAT, ST_IDLE, 8'hf8);
        rd(3'h7, 8'h00);
        repeat (3) @(posedge clk);
        finish_test();
    end
endmodule // two_wire_master_receiver_tb
`default_nettype wire

//--- two_wire_pkg.sv
// Shared constants and types for the two-wire master receiver.
package two_wire_pkg;
    // Register map on the plain register port.
    localparam logic [2:0] REG_CTRL = 3'h0;
    localparam logic [2:0] REG_STAT = 3'h1;
    localparam logic [2:0] REG_DATA = 3'h2;
    localparam logic [2:0] REG_EVST = 3'h3;
    localparam logic [2:0] REG_EVMSK = 3'h4;
    // Control register fields.
    localparam int CTRL_FLAG = 7;
    localparam int CTRL_ACK = 6;
    localparam int CTRL_STA = 5;
    localparam int CTRL_STO = 4;
    localparam int CTRL_EN = 2;
    // Status register fields: code in the top five bits, prescaler in the low two.
    localparam int STAT_CODE_LSB = 3;
    localparam int PRESC_W = 2;
    // Status codes, prescaler bits zero.
    localparam logic [7:0] ST_START = 8'h08;
    localparam logic [7:0] ST_REP = 8'h10;
    localparam logic [7:0] ST_WADDR_ACK = 8'h18;
    localparam logic [7:0] ST_WADDR_NACK = 8'h20;
    localparam logic [7:0] ST_ARB = 8'h38;
    localparam logic [7:0] ST_ADDR_ACK = 8'h40;
    localparam logic [7:0] ST_ADDR_NACK = 8'h48;
    localparam logic [7:0] ST_DATA_ACK = 8'h50;
    localparam logic [7:0] ST_DATA_NACK = 8'h58;
    localparam logic [7:0] ST_IDLE = 8'hf8;
    // Event bits of the interrupt status and mask registers.
    localparam int EV_W = 3;
    localparam int EV_DONE = 0;
    localparam int EV_ARB = 1;
    localparam int EV_STOP = 2;
    localparam logic [EV_W-1:0] EV_RST = 3'h0;
    // Bus timing: one bit is four quarter periods.
    localparam int CLK_PERIOD_NS = 25;
    localparam int QTR_TIME_NS = 2500;
    localparam int QTR_CYC = QTR_TIME_NS / CLK_PERIOD_NS;
    localparam int QTR_W = 7;
    localparam logic [QTR_W-1:0] QTR_LAST = QTR_W'(QTR_CYC - 1);
    // Frame: eight data bits then the acknowledge bit.
    localparam logic [3:0] ACK_BIT = 4'h8;
    localparam logic [1:0] PH_DRIVE = 2'h0;
    localparam logic [1:0] PH_RISE = 2'h1;
    localparam logic [1:0] PH_HIGH = 2'h2;
    localparam logic [1:0] PH_FALL = 2'h3;

    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_WAIT_FREE = 3'b001,
        S_START = 3'b010,
        S_XFER = 3'b011,
        S_HOLD = 3'b100,
        S_STOP = 3'b101
    } state_t;
endpackage
